//--- rtl/btbc_addr_form.sv
// forms the 12-bit data address from file address, access bit, bank and, in indexed mode, index base
// assumes purely combinational use inside one clock domain
`timescale 1ns/1ps
`default_nettype none
module btbc_addr_form (
  btbc_addr_if.former port_if
);
  wire logic low_access = port_if.file_addr <= btbc_pkg::ACCESS_LIMIT;
  wire logic indexed = port_if.ext_set_en && low_access;
  wire logic [7:0] indexed_low = port_if.index_base + port_if.file_addr;
  wire logic [11:0] access_addr = low_access ? {4'h0, port_if.file_addr} : {btbc_pkg::SFR_BANK, port_if.file_addr};
  assign port_if.data_addr = port_if.access_sel ? {port_if.bank, port_if.file_addr}
    : indexed ? {4'h0, indexed_low}
    : access_addr;
endmodule
`default_nettype wire

//--- rtl/btbc_addr_if.sv
// address request between the executor and the address former
// assumes both ends on the core clock
`timescale 1ns/1ps
`default_nettype none
interface btbc_addr_if;
  logic [7:0] file_addr;
  logic access_sel;
  logic [3:0] bank;
  logic ext_set_en;
  logic [7:0] index_base;
  logic [11:0] data_addr;
  modport requester (output file_addr, access_sel, bank, ext_set_en, index_base, input data_addr);
  modport former (input file_addr, access_sel, bank, ext_set_en, index_base, output data_addr);
endinterface
`default_nettype wire

//--- rtl/btbc_core.sv
// executor for toggle, clear, branch-on-overflow and watchdog clear
// assumes fetch holds instr_in valid for all four quarter cycles of an instruction
// assumes data memory read data settles before the edge after the read strobe
`timescale 1ns/1ps
`default_nettype none
module btbc_core (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // instruction and state
  input wire logic [15:0] instr_in,
  input wire logic overflow_in,
  input wire logic ext_set_en_in,
  input wire logic [7:0] index_base_in,
  input wire logic [3:0] bank_select_register_in,
  // data memory
  input wire logic [7:0] mem_rdata_in,
  output logic [11:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  // flags, pc, watchdog, flush and quarter
  output logic zero_set_out,
  output logic watchdog_clear_out,
  output logic timeout_flag_n_out,
  output logic powerdown_flag_n_out,
  output logic [20:0] program_counter_out,
  output logic flush_out,
  output logic [1:0] quarter_out
);
  logic rst_meta;
  logic rst_sync;
  btbc_pkg::btbc_q_t q;
  btbc_pkg::btbc_q_t next_q;
  logic [7:0] operand;
  wire logic [7:0] result;
  logic [3:0] phase;
  logic stall_nop;

  // async assert, clocked release, so no flop leaves reset a quarter apart from the rest
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // address former is pure logic, so the address settles within Q1
  btbc_addr_if addr_bus ();
  btbc_addr_form u_addr (
    .port_if(addr_bus)
  );

  // decodes look only at the held word; fetch keeps it steady for the whole cycle
  wire logic is_toggle = instr_in[15:12] == btbc_pkg::OP_TOGGLE;
  wire logic is_clear = instr_in[15:9] == btbc_pkg::OP_CLEAR;
  wire logic is_branch = instr_in[15:8] == btbc_pkg::OP_BRANCH_OV;
  wire logic is_wdt = instr_in == btbc_pkg::OP_WDT_CLEAR;
  wire logic is_file = is_toggle || is_clear;
  wire logic [2:0] bit_index = instr_in[11:9];
  wire logic [20:0] branch_offset = {{12{instr_in[7]}}, instr_in[7:0], 1'b0};
  wire logic take_branch = is_branch && overflow_in && !stall_nop;
  // second cycle of a taken branch executes as a no-op
  wire logic active = !stall_nop;
  wire logic file_step = active && is_file;
  wire logic [20:0] seq_pc = program_counter_out + btbc_pkg::PC_STEP;
  wire logic [20:0] branch_pc = seq_pc + branch_offset;

  assign addr_bus.file_addr = instr_in[7:0];
  assign addr_bus.access_sel = instr_in[8];
  assign addr_bus.bank = bank_select_register_in;
  assign addr_bus.ext_set_en = ext_set_en_in;
  assign addr_bus.index_base = index_base_in;
  // counter wraps from Q4 back to Q1 by plain overflow
  assign next_q = btbc_pkg::btbc_q_t'(q + 2'b01);

  // one-hot view of the quarter, so each strobe below is a single gate
  always_comb begin
    phase = 4'h0;
    case (q)
      btbc_pkg::BTBC_Q1: begin
        phase = 4'h1;
      end
      btbc_pkg::BTBC_Q2: begin
        phase = 4'h2;
      end
      btbc_pkg::BTBC_Q3: begin
        phase = 4'h4;
      end
      btbc_pkg::BTBC_Q4: begin
        phase = 4'h8;
      end
      default: begin
        phase = 4'h0;
      end
    endcase
  end

  wire logic issue_read = phase[0] && file_step;
  wire logic take_operand = phase[1];
  wire logic issue_write = phase[2] && file_step;
  wire logic issue_wdt = phase[2] && active && is_wdt;
  wire logic end_of_cycle = phase[3];

  // per-bit update: only the chosen bit flips, a clear drops every bit
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign result[i] = is_clear ? 1'b0 : operand[i] ^ (is_toggle && bit_index == 3'(i));
  end

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      q <= btbc_pkg::BTBC_Q1;
    end else begin
      q <= next_q;
    end
  end

  // address is issued at the end of Q1 so the read lands in Q2; it then stands for the write
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      mem_addr_out <= 12'h000;
    end else if (issue_read) begin
      mem_addr_out <= addr_bus.data_addr;
    end
  end

  // strobes are one-quarter pulses; nothing holds them across quarters
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      zero_set_out <= 1'b0;
    end else begin
      mem_rd_out <= issue_read;
      mem_wr_out <= issue_write;
      zero_set_out <= issue_write && is_clear;
    end
  end

  // operand is taken at the Q2 edge, one edge after the read strobe rose
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      operand <= 8'h00;
    end else if (take_operand) begin
      operand <= mem_rdata_in;
    end
  end

  // write data stands until the next file op writes
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      mem_wdata_out <= 8'h00;
    end else if (issue_write) begin
      mem_wdata_out <= result;
    end
  end

  // clear pulse only; counter and postscaler themselves sit outside
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      watchdog_clear_out <= 1'b0;
    end else begin
      watchdog_clear_out <= issue_wdt;
    end
  end

  // flags are set-only here; the events that clear them live outside this block
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      timeout_flag_n_out <= 1'b1;
      powerdown_flag_n_out <= 1'b1;
    end else if (issue_wdt) begin
      timeout_flag_n_out <= 1'b1;
      powerdown_flag_n_out <= 1'b1;
    end
  end

  // quarter shown to fetch is the state after this edge
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      quarter_out <= 2'b00;
    end else begin
      quarter_out <= next_q;
    end
  end

  // a taken branch marks the following instruction cycle as a no-op
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      stall_nop <= 1'b0;
      flush_out <= 1'b0;
    end else begin
      flush_out <= end_of_cycle && take_branch;
      if (end_of_cycle) begin
        stall_nop <= take_branch;
      end
    end
  end

  // the counter moves only at Q4, and not at all in the no-op cycle
  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      program_counter_out <= btbc_pkg::PC_RESET;
    end else if (end_of_cycle && take_branch) begin
      program_counter_out <= branch_pc;
    end else if (end_of_cycle && !stall_nop) begin
      program_counter_out <= seq_pc;
    end
  end
endmodule
`default_nettype wire

//--- rtl/btbc_pkg.sv
// package for the bit toggle / branch / clear decoder
// assumes a 16-bit instruction word and 12-bit data addresses
package btbc_pkg;
  localparam logic [3:0] OP_TOGGLE = 4'h7;
  localparam logic [6:0] OP_CLEAR = 7'h35;
  localparam logic [7:0] OP_BRANCH_OV = 8'hE4;
  localparam logic [15:0] OP_WDT_CLEAR = 16'h0004;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SFR_BASE = 8'h60;
  localparam logic [3:0] SFR_BANK = 4'hF;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;

  typedef enum logic [1:0] {
    BTBC_Q1 = 2'b00,
    BTBC_Q2 = 2'b01,
    BTBC_Q3 = 2'b10,
    BTBC_Q4 = 2'b11
  } btbc_q_t;
endpackage

//--- verif/bit_toggle_branch_clear_ops_tb.sv
// self-checking bench: random toggle, clear, branch and watchdog clear
// assumes btbc_mem as data memory and the bound checker
`timescale 1ns/1ps
`default_nettype none
module bit_toggle_branch_clear_ops_tb;
  logic clk = 0, rst_n = 0, ov = 0, ext = 0, rd, wr, zs, wc, tf, pf, fl, zs_seen, wc_seen;
  logic [15:0] ins = 16'h0000;
  logic [7:0] ib = 8'h00, rdat, wd;
  logic [3:0] bank_select_register = 4'h0;
  logic [11:0] ad;
  logic [20:0] pc, epc = 21'h0;
  logic [1:0] q;
  logic [31:0] r = 32'h1069;
  int fails = 0, compares = 0;
  always #4 clk = ~clk;
  btbc_core dut (.clk_in(clk), .rst_n_in(rst_n), .instr_in(ins), .overflow_in(ov), .ext_set_en_in(ext),
    .index_base_in(ib), .bank_select_register_in(bank_select_register), .mem_rdata_in(rdat), .mem_addr_out(ad), .mem_rd_out(rd),
    .mem_wr_out(wr), .mem_wdata_out(wd), .zero_set_out(zs), .watchdog_clear_out(wc), .timeout_flag_n_out(tf),
    .powerdown_flag_n_out(pf), .program_counter_out(pc), .flush_out(fl), .quarter_out(q));
  btbc_mem mem (.clk_in(clk), .rd_in(rd), .wr_in(wr), .addr_in(ad), .wdata_in(wd), .rdata_out(rdat));
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] eaddr(logic a, logic [7:0] f);
    if (a) return {bank_select_register, f};
    if (f > 8'h5F) return {4'hF, f};
    return ext ? {4'h0, 8'(ib + f)} : {4'h0, f};
  endfunction
  task automatic chk(logic ok, string s);
    compares++;
    if (!ok) begin
      fails++;
      $display("BAD %0t %s", $time, s);
    end
  endtask
  task automatic run(logic [15:0] w);
    ins = w;
    zs_seen = 0;
    wc_seen = 0;
    repeat (4) begin
      @(posedge clk);
      #1;
      zs_seen |= zs;
      wc_seen |= wc;
    end
    chk(q === 2'b00, "phase");
  endtask
  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    print_verdict;
  end
  initial begin
    logic [7:0] f, old;
    logic [11:0] ea;
    logic [2:0] b;
    logic a;
    repeat (20) @(posedge clk);
    #1 rst_n = 1;
    for (int i = 0; i < 8 && (i < 3 || q !== 2'h0); i++) begin
      @(posedge clk);
      #1;
    end
    // the alignment cycle ran one plain word, so the counter has already stepped once
    epc = 21'h2;
    for (int i = 0; i < 40; i++) begin
      repeat (32) r = lfsr(r);
      {ov, b, ext, bank_select_register, ib} = r[16:0];
      // first passes straddle the access bank split
      f = i < 4 ? 8'h5F + 8'(i) : r[24:17];
      a = i < 4 ? 1'b0 : r[25];
      ea = eaddr(a, f);
      old = mem.m[ea];
      run({4'h7, b, a, f});
      epc += 21'h2;
      chk(mem.m[ea] === (old ^ (8'h01 << b)) && pc === epc, "toggle");
      run({7'h35, a, ~f});
      epc += 21'h2;
      chk(mem.m[eaddr(a, ~f)] === 8'h00 && zs_seen === 1'b1, "clear");
      run(16'h0004);
      epc += 21'h2;
      chk(wc_seen === 1'b1 && tf === 1'b1 && pf === 1'b1, "wdt");
      run({8'hE4, f});
      epc += 21'h2 + (ov ? {{12{f[7]}}, f, 1'b0} : 21'h0);
      chk(pc === epc && fl === ov, "branch");
      if (ov) begin
        run(16'h0000);
        chk(pc === epc, "no-op");
      end
    end
    print_verdict;
  end
endmodule
`default_nettype wire

//--- verif/btbc_core_chk.sv
// port assertions for btbc_core
// bound to the core, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module btbc_core_chk (
  // watched ports
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] instr_in,
  input wire logic overflow_in,
  input wire logic ext_set_en_in,
  input wire logic [7:0] index_base_in,
  input wire logic [3:0] bank_select_register_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic [11:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic zero_set_out,
  input wire logic watchdog_clear_out,
  input wire logic timeout_flag_n_out,
  input wire logic powerdown_flag_n_out,
  input wire logic [20:0] program_counter_out,
  input wire logic flush_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic [7:0] f = instr_in[7:0];
  wire logic rd0 = mem_rd_out && !instr_in[8];
  wire logic lo = f <= 8'h5F;
  property p_tog; mem_wr_out && !zero_set_out |-> instr_in[15:12] == 4'h7 && $past(mem_rd_out, 2)
    && mem_wdata_out == ($past(mem_rdata_in, 2) ^ (8'h01 << instr_in[11:9])); endproperty
  a_tog: assert property (p_tog) else $error("toggle");
  property p_clr; zero_set_out |-> mem_wr_out && mem_wdata_out == 8'h00 && instr_in[15:9] == 7'h35; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_bank; mem_rd_out && instr_in[8] |-> mem_addr_out == {bank_select_register_in, f}; endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_acc; rd0 && !(ext_set_en_in && lo) |-> mem_addr_out == {lo ? 4'h0 : 4'hF, f}; endproperty
  a_acc: assert property (p_acc) else $error("access");
  property p_idx; rd0 && ext_set_en_in && lo |-> mem_addr_out == {4'h0, 8'(index_base_in + f)}; endproperty
  a_idx: assert property (p_idx) else $error("index");
  property p_wdt; watchdog_clear_out |-> instr_in == 16'h0004 ##1 timeout_flag_n_out && powerdown_flag_n_out;
  endproperty
  a_wdt: assert property (p_wdt) else $error("wdt");
  property p_br; flush_out |-> $past(overflow_in) && $past(instr_in[15:8]) == 8'hE4 && program_counter_out ==
    $past(program_counter_out) + 21'h2 + {{12{$past(instr_in[7])}}, $past(instr_in[7:0]), 1'b0}; endproperty
  a_br: assert property (p_br) else $error("branch");
  property p_nop; flush_out |=> (!mem_rd_out && !mem_wr_out && $stable(program_counter_out)) [*4]; endproperty
  a_nop: assert property (p_nop) else $error("no-op");
endmodule
bind btbc_core btbc_core_chk chk (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .instr_in(instr_in),
  .overflow_in(overflow_in),
  .ext_set_en_in(ext_set_en_in),
  .index_base_in(index_base_in),
  .bank_select_register_in(bank_select_register_in),
  .mem_rdata_in(mem_rdata_in),
  .mem_addr_out(mem_addr_out),
  .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out),
  .mem_wdata_out(mem_wdata_out),
  .zero_set_out(zero_set_out),
  .watchdog_clear_out(watchdog_clear_out),
  .timeout_flag_n_out(timeout_flag_n_out),
  .powerdown_flag_n_out(powerdown_flag_n_out),
  .program_counter_out(program_counter_out),
  .flush_out(flush_out)
);
`default_nettype wire

//--- verif/btbc_mem.sv
// data memory model on the far side of the decoder
// assumes strobes and address from btbc_core
`timescale 1ns/1ps
`default_nettype none
module btbc_mem (
  // strobes and data
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] m [4096];
  initial foreach (m[i]) m[i] = 8'(i * 3);
  // undriven bus shows junk, so a late sample cannot pass
  assign rdata_out = rd_in ? m[addr_in] : ~m[addr_in];
  always @(posedge clk_in) if (wr_in) m[addr_in] <= wdata_in;
endmodule
`default_nettype wire
